// [design/flash_power_pkg.sv]
// Package: constants, states and carriers of the flash power-mode and status block
package flash_power_pkg;

  // Opcodes recognised at frame end
  localparam logic [7:0] OP_DPD_ENTER  = 8'hB9;
  localparam logic [7:0] OP_DPD_RESUME = 8'hAB;
  localparam logic [7:0] OP_UDPD_ENTER = 8'h79;

  // Bits per opcode byte
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [2:0]  BIT_LAST  = 3'h7;
  localparam logic [2:0]  BIT_FIRST = 3'h1;
  localparam logic [2:0]  BIT_ZERO  = 3'h0;

  // Clock and mode timings (ns); plain defaults, no figures are given
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned DPD_ENTRY_NS   = 3000;
  localparam int unsigned DPD_EXIT_NS    = 35000;
  localparam int unsigned UDPD_ENTRY_NS  = 3000;
  localparam int unsigned UDPD_WAKE_NS   = 20;
  localparam int unsigned UDPD_EXIT_NS   = 100000;

  // Longest times round down, least time rounds up, none below one cycle
  function automatic int unsigned max_cycles(input int unsigned ns);
    max_cycles = (ns / CLK_PERIOD_NS < 1) ? 1 : ns / CLK_PERIOD_NS;
  endfunction

  function automatic int unsigned min_cycles(input int unsigned ns);
    min_cycles = ((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
                 (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  localparam int unsigned TIMER_W = 16;

  // Status word layout: upper byte first, lower byte second
  localparam int unsigned ST_RDY_HI  = 15;
  localparam int unsigned ST_COMP    = 14;
  localparam int unsigned ST_DENS_HI = 13;
  localparam int unsigned ST_DENS_LO = 10;
  localparam int unsigned ST_PROT    = 9;
  localparam int unsigned ST_PAGE    = 8;
  localparam int unsigned ST_RDY_LO  = 7;
  localparam int unsigned ST_EPE     = 5;
  localparam int unsigned ST_SLE     = 3;
  localparam int unsigned ST_PS2     = 2;
  localparam int unsigned ST_PS1     = 1;
  localparam int unsigned ST_ES      = 0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // Density code for legacy compatibility; the value is arbitrary
  localparam logic [3:0] DENSITY_CODE_DEFAULT = 4'h5;

  // Power modes, Gray coded along standby, entry, mode, exit; ultra-deep steps from and back to standby flip two bits
  typedef enum logic [2:0] {
    PM_STANDBY    = 3'h0,
    PM_DPD_ENTER  = 3'h1,
    PM_DPD        = 3'h3,
    PM_DPD_EXIT   = 3'h2,
    PM_UDPD_ENTER = 3'h6,
    PM_UDPD       = 3'h7,
    PM_UDPD_EXIT  = 3'h5
  } power_mode_t;

  // Link-side frame capture, held static once the frame closes
  typedef struct packed {
    logic       whole;
    logic [2:0] bit_idx;
    logic [7:0] opcode;
  } link_frame_t;

  // Flag inputs from the memory core
  typedef struct packed {
    logic busy;
    logic compare_done;
    logic compare_differs;
    logic protect_sw;
    logic protect_hw;
    logic page_size_512;
    logic pe_done;
    logic pe_failed;
    logic pe_aborted;
    logic lockdown_disabled;
    logic buf1_suspended;
    logic buf2_suspended;
    logic erase_suspended;
    logic buf_write;
  } core_flags_t;

endpackage

// [design/flash_power_mode.sv]
// Power-mode sequencer and status word of a serial flash device
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Compare mismatch flag follows latest compare
// - Fixed legacy density code in status
// - Protect flag set for software or hardware
// - Page size flag shows 512 or 528
// - Error flag updated after each non-aborted program/erase
// - Aborted program/erase never sets error flag
// - Lockdown flag shows lockdown command still usable
// - Suspended buffer refuses modifying commands
// - Erase suspend flag while erase suspended
// - Standby while deselected and not busy
// - Deep power-down ignores all but resume
// - B9h then deselect enters deep power-down
// - Short or misaligned entry frame aborts
// - Entry commands ignored while busy
// - Power cycle always starts in standby
// - ABh then deselect resumes to standby
// - Bad resume frame stays in deep power-down
// - 79h then deselect enters ultra-deep power-down
// - Ultra-deep power-down ignores every command
// - Buffers undefined after ultra-deep power-down
// - Long select pulse wakes from ultra-deep
// - Frames during ultra-deep exit are ignored
// - Ready bit 7 of both status bytes
module flash_power_mode
  import flash_power_pkg::*;
#(
  parameter logic [3:0]  DENSITY_CODE   = DENSITY_CODE_DEFAULT,
  parameter int unsigned DPD_ENTRY_CYC  = max_cycles(DPD_ENTRY_NS),
  parameter int unsigned DPD_EXIT_CYC   = max_cycles(DPD_EXIT_NS),
  parameter int unsigned UDPD_ENTRY_CYC = max_cycles(UDPD_ENTRY_NS),
  parameter int unsigned UDPD_WAKE_CYC  = min_cycles(UDPD_WAKE_NS),
  parameter int unsigned UDPD_EXIT_CYC  = max_cycles(UDPD_EXIT_NS)
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  input  wire core_flags_t core,
  output var  logic [15:0] device_status_word,
  output var  power_mode_t power_mode,
  output var  logic        standby,
  output var  logic        cmd_enable,
  output var  logic        buf1_write_enable,
  output var  logic        buf2_write_enable,
  output var  logic        buffers_undefined
);

  // Serial clock domain: opcode and bit count of the current frame
  link_frame_t link_q;
  link_frame_t link_d;
  logic        frame_open_q;

  // Cleared by deselect so the first edge of every frame restarts the count
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      frame_open_q <= 1'b0;
    end else begin
      frame_open_q <= 1'b1;
    end
  end

  always_comb begin
    link_d = link_q;
    if (!frame_open_q) begin
      link_d.bit_idx = BIT_FIRST;
      link_d.whole   = 1'b0;
      link_d.opcode  = {7'h00, si};
    end else begin
      link_d.bit_idx = link_q.bit_idx + BIT_FIRST;
      if (!link_q.whole) begin
        link_d.opcode = {link_q.opcode[6:0], si};
        if (link_q.bit_idx == BIT_LAST) begin
          link_d.whole = 1'b1;
        end
      end
    end
  end

  // Bits after the opcode shift nothing in; they only advance the bit count
  always_ff @(posedge sck) begin
    link_q <= link_d;
  end

  // System clock domain state
  typedef struct packed {
    logic               cs_s1;
    logic               cs_s2;
    logic               cs_s3;
    logic               open_s1;
    logic               open_s2;
    logic               had_edges;
    power_mode_t        mode;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] low_cnt;
    logic               comp;
    logic               erase_program_error_flag;
    logic [15:0]        status;
    logic               standby;
    logic               cmd_enable;
    logic               buf1_we;
    logic               buf2_we;
    logic               buf_undef;
  } state_t;

  localparam state_t STATE_RESET = '{
    cs_s1:      1'b1,
    cs_s2:      1'b1,
    cs_s3:      1'b1,
    open_s1:    1'b0,
    open_s2:    1'b0,
    had_edges:  1'b0,
    mode:       PM_STANDBY,
    timer:      '0,
    low_cnt:    '0,
    comp:       1'b0,
    erase_program_error_flag:        1'b0,
    status:     STATUS_RESET,
    standby:    1'b0,
    cmd_enable: 1'b0,
    buf1_we:    1'b0,
    buf2_we:    1'b0,
    buf_undef:  1'b0
  };

  state_t q;
  state_t n;

  // Frame close seen through the two-stage synchroniser
  logic frame_end;
  logic frame_ok;
  logic wake_long;

  // The frame data is static once the link clock stops at deselect
  assign frame_end = q.cs_s2 && !q.cs_s3;
  assign frame_ok  = q.had_edges && link_q.whole && (link_q.bit_idx == BIT_ZERO);
  assign wake_long = q.low_cnt >= TIMER_W'(UDPD_WAKE_CYC);

  always_comb begin
    n       = q;
    n.cs_s1 = cs_n;
    n.cs_s2 = q.cs_s1;
    n.cs_s3 = q.cs_s2;
    n.open_s1 = frame_open_q;
    n.open_s2 = q.open_s1;

    // A frame without serial clocks leaves the last opcode behind; never reuse it
    if (frame_end) begin
      n.had_edges = 1'b0;
    end else if (!q.cs_s2 && q.open_s2) begin
      n.had_edges = 1'b1;
    end

    // Select time only matters for the ultra-deep wake pulse
    if (!q.cs_s2) begin
      if (!(&q.low_cnt)) begin
        n.low_cnt = q.low_cnt + TIMER_W'(1);
      end
    end else begin
      n.low_cnt = '0;
    end

    if (q.timer != '0) begin
      n.timer = q.timer - TIMER_W'(1);
    end

    case (q.mode)
      PM_STANDBY: begin
        // Entry is refused outright while a timed operation runs
        if (frame_end && frame_ok && !core.busy) begin
          if (link_q.opcode == OP_DPD_ENTER) begin
            n.mode  = PM_DPD_ENTER;
            n.timer = TIMER_W'(DPD_ENTRY_CYC);
          end else if (link_q.opcode == OP_UDPD_ENTER) begin
            n.mode  = PM_UDPD_ENTER;
            n.timer = TIMER_W'(UDPD_ENTRY_CYC);
          end
        end
      end
      PM_DPD_ENTER: begin
        if (q.timer == '0) begin
          n.mode = PM_DPD;
        end
      end
      PM_DPD: begin
        if (frame_end && frame_ok && link_q.opcode == OP_DPD_RESUME) begin
          n.mode  = PM_DPD_EXIT;
          n.timer = TIMER_W'(DPD_EXIT_CYC);
        end
      end
      PM_DPD_EXIT: begin
        if (q.timer == '0) begin
          n.mode = PM_STANDBY;
        end
      end
      PM_UDPD_ENTER: begin
        if (q.timer == '0) begin
          n.mode      = PM_UDPD;
          n.buf_undef = 1'b1;
        end
      end
      PM_UDPD: begin
        // Any opcode bits in the wake pulse are never decoded
        if (frame_end && wake_long) begin
          n.mode  = PM_UDPD_EXIT;
          n.timer = TIMER_W'(UDPD_EXIT_CYC);
        end
      end
      PM_UDPD_EXIT: begin
        if (q.timer == '0) begin
          n.mode = PM_STANDBY;
        end
      end
      default: begin
        n.mode = PM_STANDBY;
      end
    endcase

    // Buffer contents become known again once software writes a buffer
    if (core.buf_write && q.mode == PM_STANDBY) begin
      n.buf_undef = 1'b0;
    end

    if (core.compare_done) begin
      n.comp = core.compare_differs;
    end
    if (core.pe_done && !core.pe_aborted) begin
      n.erase_program_error_flag = core.pe_failed;
    end

    n.status                        = '0;
    n.status[ST_RDY_HI]             = !core.busy;
    n.status[ST_RDY_LO]             = !core.busy;
    n.status[ST_COMP]               = n.comp;
    n.status[ST_DENS_HI:ST_DENS_LO] = DENSITY_CODE;
    n.status[ST_PROT]               = core.protect_sw || core.protect_hw;
    n.status[ST_PAGE]               = core.page_size_512;
    n.status[ST_EPE]                = n.erase_program_error_flag;
    n.status[ST_SLE]                = !core.lockdown_disabled;
    n.status[ST_PS2]                = core.buf2_suspended;
    n.status[ST_PS1]                = core.buf1_suspended;
    n.status[ST_ES]                 = core.erase_suspended;

    n.standby    = (n.mode == PM_STANDBY) && q.cs_s2 && !core.busy;
    // No command, status read included, is passed on outside standby
    n.cmd_enable = (n.mode == PM_STANDBY);
    n.buf1_we    = n.cmd_enable && !core.buf1_suspended;
    n.buf2_we    = n.cmd_enable && !core.buf2_suspended;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= STATE_RESET;
    end else begin
      q <= n;
    end
  end

  assign device_status_word = q.status;
  assign power_mode         = q.mode;
  assign standby            = q.standby;
  assign cmd_enable         = q.cmd_enable;
  assign buf1_write_enable  = q.buf1_we;
  assign buf2_write_enable  = q.buf2_we;
  assign buffers_undefined  = q.buf_undef;

  // Checks on the system clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  dpd_entry_a: assert property (
    q.mode == PM_STANDBY && frame_end && frame_ok && !core.busy &&
    link_q.opcode == OP_DPD_ENTER |=> q.mode == PM_DPD_ENTER)
    else $error("deep power-down entry not started");

  busy_ignore_a: assert property (
    q.mode == PM_STANDBY && core.busy |=> q.mode == PM_STANDBY)
    else $error("power-down entered while busy");

  bad_frame_a: assert property (
    q.mode == PM_STANDBY && frame_end && !frame_ok |=> q.mode == PM_STANDBY)
    else $error("misaligned frame left standby");

  dpd_resume_a: assert property (
    q.mode == PM_DPD && !(frame_end && frame_ok && link_q.opcode == OP_DPD_RESUME)
    |=> q.mode == PM_DPD)
    else $error("deep power-down left without resume");

  udpd_hold_a: assert property (
    q.mode == PM_UDPD && !(frame_end && wake_long) |=> q.mode == PM_UDPD)
    else $error("ultra-deep power-down left without wake pulse");

  udpd_exit_a: assert property (
    q.mode == PM_UDPD_EXIT && q.timer == '0 |=> q.mode == PM_STANDBY)
    else $error("ultra-deep exit did not reach standby");

  cmd_gate_a: assert property (
    q.mode != PM_STANDBY |-> !q.cmd_enable)
    else $error("commands enabled outside standby");

  epe_abort_a: assert property (
    core.pe_done && core.pe_aborted && !core.busy ##0 q.mode == PM_STANDBY
    |=> $stable(q.status[ST_EPE]))
    else $error("error flag changed on aborted operation");

  compare_a: assert property (
    core.compare_done |-> ##2 q.status[ST_COMP] == $past(core.compare_differs, 2))
    else $error("compare flag does not follow compare");

  ready_a: assert property (
    reset_n |=> (q.status[ST_RDY_HI] == q.status[ST_RDY_LO]) &&
    (q.status[ST_RDY_LO] == !$past(core.busy)))
    else $error("ready bits disagree with busy");

  buf_lock_a: assert property (
    core.buf1_suspended |=> !q.buf1_we)
    else $error("suspended buffer still writable");

  udpd_buf_a: assert property (
    q.mode == PM_UDPD_ENTER && q.timer == '0 |=> q.buf_undef)
    else $error("buffers not marked undefined");

  idle_standby_a: assert property (
    q.mode == PM_STANDBY && q.cs_s2 && !frame_end && !core.busy |=> q.standby)
    else $error("standby not reported while idle");

  buf2_lock_a: assert property (
    core.buf2_suspended |=> !q.buf2_we)
    else $error("suspended buffer two still writable");

  stale_frame_a: assert property (
    q.mode == PM_STANDBY && frame_end && !q.had_edges |=> q.mode == PM_STANDBY)
    else $error("frame without clock edges left standby");

  epe_update_a: assert property (
    core.pe_done && !core.pe_aborted |=> q.status[ST_EPE] == $past(core.pe_failed))
    else $error("error flag not updated after operation");

  dpd_entry_c:   cover property (q.mode == PM_DPD_ENTER ##1 q.mode == PM_DPD);
  dpd_resume_c:  cover property (q.mode == PM_DPD_EXIT ##1 q.mode == PM_STANDBY);
  udpd_wake_c:   cover property (q.mode == PM_UDPD_EXIT ##1 q.mode == PM_STANDBY);
  bad_frame_c:   cover property (q.mode == PM_STANDBY && frame_end && !frame_ok);

endmodule // flash_power_mode

`default_nettype wire

// [verification/spi_host_model.sv]
// SPI host model that frames opcodes toward the power-mode block
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  output var logic sck,
  output var logic cs_n,
  output var logic si
);
  localparam int unsigned HALF_NS = 40;

  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // Clock out nbits MSB first; sck rests low outside frames
  task automatic frame(input logic [15:0] data, input int nbits, input int tail_ns);
    int i;
    cs_n = 1'b0;
    #HALF_NS;
    for (i = 0; i < nbits; i++) begin
      si = data[15 - i];
      #HALF_NS sck = 1'b1;
      #HALF_NS sck = 1'b0;
    end
    #(HALF_NS + tail_ns);
    cs_n = 1'b1;
    // Released line flips so a stale bit cannot pass for data
    si = ~si;
    // Gap well above the synchroniser window
    #200;
  endtask
endmodule // spi_host_model

`default_nettype wire

// [verification/tb_flash_power_mode.sv]
// Self-checking bench for the flash power-mode and status block
`timescale 1ns/1ps
`default_nettype none

module tb_flash_power_mode;
  import flash_power_pkg::*;
  localparam logic [3:0]  DENS = 4'hC;
  localparam int unsigned UX   = 200;
  logic        clk, reset_n, sck, cs_n, si;
  logic        standby, cmd_en, b1_we, b2_we, buf_undef;
  logic        comp_q, epe_q;
  logic [15:0] status;
  core_flags_t core;
  power_mode_t mode;
  int          err_count, tests_run;
  // busy cmp_done differs p_sw p_hw pg512 pe_done fail abort lock_dis buf1 buf2 erase buf_wr
  logic [13:0] steps [13] = '{14'h1800, 14'h1000, 14'h0400, 14'h0200, 14'h0100, 14'h00C0,
                              14'h0080, 14'h00E0, 14'h0010, 14'h0008, 14'h0004, 14'h0002,
                              14'h2000};

  flash_power_mode #(.DENSITY_CODE(DENS), .DPD_ENTRY_CYC(4), .DPD_EXIT_CYC(4),
    .UDPD_ENTRY_CYC(4), .UDPD_WAKE_CYC(12), .UDPD_EXIT_CYC(UX)) u_dut (
    .clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si), .core(core),
    .device_status_word(status), .power_mode(mode), .standby(standby),
    .cmd_enable(cmd_en), .buf1_write_enable(b1_we), .buf2_write_enable(b2_we),
    .buffers_undefined(buf_undef));

  spi_host_model u_host (.sck(sck), .cs_n(cs_n), .si(si));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wait_mode(input power_mode_t m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({13'h0, mode}, {13'h0, m});
  endtask

  // Refused frames must leave the mode alone after the sync delay
  task automatic settle(input power_mode_t m);
    repeat (12) @(posedge clk);
    #1;
    check({13'h0, mode}, {13'h0, m});
  endtask

  // Pulses last one cycle; levels hold until the next step
  task automatic apply(input logic [13:0] v);
    core_flags_t c;
    c = core_flags_t'(v);
    if (c.compare_done) comp_q = c.compare_differs;
    if (c.pe_done && !c.pe_aborted) epe_q = c.pe_failed;
    @(posedge clk);
    core <= c;
    @(posedge clk);
    core <= c & ~14'h1081;
    #1;
    check(status, {~c.busy, comp_q, DENS, c.protect_sw | c.protect_hw, c.page_size_512,
                   ~c.busy, 1'b0, epe_q, 1'b0, ~c.lockdown_disabled, c.buf2_suspended,
                   c.buf1_suspended, c.erase_suspended});
    check({12'h0, standby, cmd_en, b1_we, b2_we},
          {12'h0, ~c.busy, 1'b1, ~c.buf1_suspended, ~c.buf2_suspended});
  endtask

  initial begin
    #100000;
    err_count++;
    complete_run();
  end

  initial begin
    int n;
    reset_n   = 1'b0;
    core      = '0;
    comp_q    = 1'b0;
    epe_q     = 1'b0;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    check({13'h0, mode}, {13'h0, PM_STANDBY});
    foreach (steps[k]) apply(steps[k]);
    u_host.frame(16'hB900, 8, 0);
    settle(PM_STANDBY);
    @(posedge clk);
    core <= '0;
    n = 0;
    while (status[15] !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({15'h0, status[15]}, 16'h0001);
    u_host.frame(16'h0000, 0, 0);
    settle(PM_STANDBY);
    u_host.frame(16'hB900, 7, 0);
    settle(PM_STANDBY);
    u_host.frame(16'hB900, 9, 0);
    settle(PM_STANDBY);
    u_host.frame(16'hB955, 16, 0);
    wait_mode(PM_DPD, 40);
    check({15'h0, cmd_en}, 16'h0000);
    u_host.frame(16'h7900, 8, 0);
    settle(PM_DPD);
    u_host.frame(16'hAB00, 12, 0);
    settle(PM_DPD);
    u_host.frame(16'hAB00, 8, 0);
    wait_mode(PM_STANDBY, 40);
    u_host.frame(16'h7900, 8, 0);
    wait_mode(PM_UDPD, 40);
    check({15'h0, buf_undef}, 16'h0001);
    u_host.frame(16'hAB00, 8, 0);
    wait_mode(PM_UDPD_EXIT, 20);
    u_host.frame(16'hB900, 8, 0);
    wait_mode(PM_STANDBY, UX + 20);
    settle(PM_STANDBY);
    u_host.frame(16'h7900, 8, 0);
    wait_mode(PM_UDPD, 40);
    u_host.frame(16'h0000, 0, 0);
    settle(PM_UDPD);
    u_host.frame(16'h0000, 0, 100);
    wait_mode(PM_STANDBY, UX + 40);
    check({15'h0, buf_undef}, 16'h0001);
    apply(14'h0001);
    check({15'h0, buf_undef}, 16'h0000);
    complete_run();
  end
endmodule // tb_flash_power_mode

`default_nettype wire
